// *** src/srse_cfg.svh ***
// constants for the response status encoder: field codes, error source positions
// assumes it is included by bare name from the package only; the design modules use its macros without including it
// Summary of operation
// - alternative-status select chooses the alternative basic status mapping
// - alternative: 00 init, 01 normal, 10 self-test, 11 error; error outranks all
// - sensor data responses carry a detailed status field beside basic status
// - detailed status is 00 with normal data unless basic status is error
// - status snapshot is taken at select rising edge ending previous command
// - detailed 00: oscillator, channel fault, temperature; echo swapped, data unchanged
// - detailed 01: user otp, user memory, factory otp; echo zero, error code
// - detailed 10 test mode: echo zero, all-zero sensor data
// - supply fault unmuted: aux off from the fault on; zeros until timer expires, then error code
// - supply fault muted: zeros until timer expires, no error code afterwards
// - detailed 11: reset occurred, miso fault, command error; echo zero, error code
`ifndef SRSE_CFG_SVH
`define SRSE_CFG_SVH

`define SRSE_NSRC 11
`define SRSE_BS_INIT 2'h0
`define SRSE_BS_NORMAL 2'h1
`define SRSE_BS_SELFTEST 2'h2
`define SRSE_BS_ERROR 2'h3
`define SRSE_DS_NONE 2'h0
// bit index of each error source is its priority number minus one
`define SRSE_P_CMD_ERR 0
`define SRSE_P_MISO 1
`define SRSE_P_RESET 2
`define SRSE_P_SUPPLY 3
`define SRSE_P_TEST 4
`define SRSE_P_FOTP 5
`define SRSE_P_URW 6
`define SRSE_P_UOTP 7
`define SRSE_P_TEMP 8
`define SRSE_P_CHAN 9
`define SRSE_P_OSC 10
`define SRSE_ECHO_ZERO 4'h0
`define SRSE_ST_IDLE 4'h0

`endif

// *** src/srse_pkg.sv ***
// types shared by the response status encoder modules
// assumes srse_cfg.svh is on the include path
`include "srse_cfg.svh"

package srse_pkg;
   // what the sensor data field of the next data response carries
   typedef enum logic [1:0] {
      SRSE_DATA_PASS,
      SRSE_DATA_ERRCODE,
      SRSE_DATA_ZERO
   } srse_data_e;

   typedef logic [`SRSE_NSRC-1:0] srse_src_t;
endpackage : srse_pkg

// *** src/srse_prio_if.sv ***
// carrier between the top and the priority encoder
// assumes srse_pkg is compiled first
`timescale 1ns/1ps
`default_nettype none

interface srse_prio_if;
   srse_pkg::srse_src_t active;
   logic any;
   logic [3:0] index;
   modport req (output active, input any, input index);
   modport enc (input active, output any, output index);
endinterface : srse_prio_if

`default_nettype wire

// *** src/srse_prio.sv ***
// picks the active error source with the lowest priority number
// assumes a purely combinational use, index meaningful only while any is high
`timescale 1ns/1ps
`default_nettype none

module srse_prio (
   srse_prio_if.enc p
);
   function automatic logic [3:0] srse_lowest(input srse_pkg::srse_src_t v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = `SRSE_NSRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction : srse_lowest

   assign p.index = srse_lowest(p.active);
   assign p.any = |p.active;
endmodule : srse_prio

`default_nettype wire

// *** src/srse_top.sv ***
// response status encoder: basic status, detailed status, echo and data substitution
// assumes error flags come from logic on clk_sys; only the select pin is asynchronous
`timescale 1ns/1ps
`default_nettype none

module srse_top #(
   parameter int NCH = 2
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // spi select pin, active low
   input wire logic sel_n,
   // configuration
   input wire logic alt_status_sel,
   input wire logic supply_fault_mute,
   // device state
   input wire logic init_done,
   input wire logic [NCH*4-1:0] selftest_ctrl,
   input wire logic [$clog2(NCH > 1 ? NCH : 2)-1:0] req_channel,
   input wire logic [3:0] cmd_nibble,
   // error sources
   input wire logic osc_train_err,
   input wire logic [NCH-1:0] offset_flag,
   input wire logic [NCH-1:0] clip_flag,
   input wire logic temp_err,
   input wire logic user_otp_err,
   input wire logic user_rw_err,
   input wire logic factory_otp_err,
   input wire logic test_active,
   input wire logic supply_fault,
   input wire logic supply_timer_expired,
   input wire logic reset_occurred,
   input wire logic miso_fault,
   input wire logic spi_cmd_err,
   // encoded response fields
   output logic [1:0] basic_status,
   output logic [1:0] detailed_status,
   output logic [3:0] echo_field,
   output var srse_pkg::srse_data_e data_mode,
   output logic aux_mode_output_en,
   output logic snap_strobe
);
   // the channel select and the self-test vector serve one to four channels only
   if (NCH < 1 || NCH > 4) begin : g_bad_nch
      $error("srse_top: NCH must be 1 to 4");
   end

   // echo carries the command source id rotated: C[0] first, then C[3:1]
   function automatic logic [3:0] srse_echo_rot(input logic [3:0] c);
      return {c[0], c[3:1]};
   endfunction : srse_echo_rot

   ////////////////////////////////////////////////////////////////////////////
   // select pin synchroniser and rising edge
   logic sel_meta_r;
   logic sel_sync_r;
   logic sel_last_r;
   wire sel_rise;

   // flops reset to the idle high level so a reset release never looks like a rise
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sel_meta_r <= 1'b1;
         sel_sync_r <= 1'b1;
         sel_last_r <= 1'b1;
      end else begin
         sel_meta_r <= sel_n;
         sel_sync_r <= sel_meta_r;
         sel_last_r <= sel_sync_r;
      end
   end

   assign sel_rise = sel_sync_r & ~sel_last_r;

   ////////////////////////////////////////////////////////////////////////////
   // error source vector, index is priority minus one
   srse_prio_if pif ();
   wire [3:0] st_assoc;
   wire st_any_chan;
   wire chan_fault;
   wire self_test;

   // per-channel self-test activity, used by the standard mapping
   wire [NCH-1:0] st_chan_on;

   for (genvar g = 0; g < NCH; g++) begin : g_st_chan
      assign st_chan_on[g] = (selftest_ctrl[g*4 +: 4] != `SRSE_ST_IDLE);
   end

   assign st_assoc = selftest_ctrl[req_channel * 4 +: 4];
   assign st_any_chan = |st_chan_on;
   // clip only counts as a channel fault under the standard mapping
   assign chan_fault = (|offset_flag) | (~alt_status_sel & (|clip_flag));

   assign pif.active[`SRSE_P_OSC] = osc_train_err;
   assign pif.active[`SRSE_P_CHAN] = chan_fault;
   assign pif.active[`SRSE_P_TEMP] = temp_err;
   assign pif.active[`SRSE_P_UOTP] = user_otp_err;
   assign pif.active[`SRSE_P_URW] = user_rw_err;
   assign pif.active[`SRSE_P_FOTP] = factory_otp_err;
   assign pif.active[`SRSE_P_TEST] = test_active;
   assign pif.active[`SRSE_P_SUPPLY] = supply_fault;
   assign pif.active[`SRSE_P_RESET] = reset_occurred;
   assign pif.active[`SRSE_P_MISO] = miso_fault;
   assign pif.active[`SRSE_P_CMD_ERR] = spi_cmd_err;

   srse_prio u_prio (
      .p(pif.enc)
   );

   ////////////////////////////////////////////////////////////////////////////
   // basic status
   wire [1:0] bs_nxt;

   assign self_test = alt_status_sel ? (st_assoc != `SRSE_ST_IDLE) : st_any_chan;
   // error, self-test, init, normal in that order
   assign bs_nxt = pif.any ? `SRSE_BS_ERROR :
                   self_test ? `SRSE_BS_SELFTEST :
                   !init_done ? `SRSE_BS_INIT : `SRSE_BS_NORMAL;

   ////////////////////////////////////////////////////////////////////////////
   // detailed status, echo and data field from the winning source
   logic [1:0] ds_nxt;
   logic [3:0] echo_nxt;
   srse_pkg::srse_data_e dm_nxt;
   wire [3:0] win;
   wire [3:0] echo_swap;

   assign win = pif.index;
   assign echo_swap = srse_echo_rot(cmd_nibble);

   always_comb begin
      // no error: zero detail, real data
      ds_nxt = `SRSE_DS_NONE;
      echo_nxt = echo_swap;
      dm_nxt = srse_pkg::SRSE_DATA_PASS;
      if (pif.any) begin
         echo_nxt = `SRSE_ECHO_ZERO;
         case (win)
            4'(`SRSE_P_OSC), 4'(`SRSE_P_CHAN), 4'(`SRSE_P_TEMP): begin
               ds_nxt = 2'h0;
               echo_nxt = echo_swap;
            end
            4'(`SRSE_P_UOTP), 4'(`SRSE_P_URW), 4'(`SRSE_P_FOTP): begin
               ds_nxt = 2'h1;
               dm_nxt = srse_pkg::SRSE_DATA_ERRCODE;
            end
            4'(`SRSE_P_TEST): begin
               ds_nxt = 2'h2;
               dm_nxt = srse_pkg::SRSE_DATA_ZERO;
            end
            4'(`SRSE_P_SUPPLY): begin
               ds_nxt = 2'h2;
               if (!supply_timer_expired) begin
                  dm_nxt = srse_pkg::SRSE_DATA_ZERO;
               end else if (!supply_fault_mute) begin
                  dm_nxt = srse_pkg::SRSE_DATA_ERRCODE;
               end else begin
                  dm_nxt = srse_pkg::SRSE_DATA_PASS;
               end
            end
            4'(`SRSE_P_RESET), 4'(`SRSE_P_MISO), 4'(`SRSE_P_CMD_ERR): begin
               ds_nxt = 2'h3;
               dm_nxt = srse_pkg::SRSE_DATA_ERRCODE;
            end
            default: begin
               ds_nxt = `SRSE_DS_NONE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // snapshot registers plus the aux and strobe flops, all outputs come from here
   logic [1:0] bs_r;
   logic [1:0] ds_r;
   logic [3:0] echo_r;
   srse_pkg::srse_data_e dm_r;
   logic aux_r;
   logic strobe_r;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         bs_r <= `SRSE_BS_INIT;
         ds_r <= `SRSE_DS_NONE;
         echo_r <= `SRSE_ECHO_ZERO;
         dm_r <= srse_pkg::SRSE_DATA_PASS;
         aux_r <= 1'b1;
         strobe_r <= 1'b0;
      end else begin
         strobe_r <= sel_rise;
         if (sel_rise) begin
            bs_r <= bs_nxt;
            ds_r <= ds_nxt;
            echo_r <= echo_nxt;
            dm_r <= dm_nxt;
         end
         // aux output off on unmuted supply fault
         aux_r <= ~(supply_fault & ~supply_fault_mute);
      end
   end

   assign basic_status = bs_r;
   assign detailed_status = ds_r;
   assign echo_field = echo_r;
   assign data_mode = dm_r;
   assign aux_mode_output_en = aux_r;
   assign snap_strobe = strobe_r;
endmodule : srse_top

`default_nettype wire

// *** sim/srse_chk_sva.sv ***
// assertions on the status encoder ports
// assumes one clock domain and a bind onto srse_top
`timescale 1ns/1ps
`default_nettype none
module srse_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // watched inputs
   input wire logic sel_n,
   input wire logic supply_fault,
   input wire logic supply_fault_mute,
   input wire logic spi_cmd_err,
   // encoded fields
   input wire logic [1:0] basic_status,
   input wire logic [1:0] detailed_status,
   input wire logic [3:0] echo_field,
   input var srse_pkg::srse_data_e data_mode,
   input wire logic aux_mode_output_en,
   input wire logic snap_strobe
);
   wire logic [9:0] flds = {basic_status, detailed_status, echo_field, data_mode};
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence sel_rise;
      $rose(sel_n);
   endsequence
   // select must have stood high two cycles before any snapshot
   sequence sel_held;
      $past(sel_n, 1) && $past(sel_n, 2);
   endsequence
   a_strobe_one_pulse: assert property (snap_strobe |=> !snap_strobe)
      else $error("strobe longer than one cycle");
   a_fields_hold: assert property (!snap_strobe |-> $stable(flds))
      else $error("fields changed without snapshot");
   a_snap_latency: assert property (sel_rise |-> ##[1:4] snap_strobe)
      else $error("no snapshot after select rise");
   a_snap_cause: assert property (snap_strobe |-> sel_held)
      else $error("snapshot without select rise");
   a_detail_none: assert property (basic_status != 2'h3 |-> detailed_status == 2'h0)
      else $error("detailed status set without error");
   a_echo_cleared: assert property (basic_status == 2'h3 && detailed_status[0] |->
      echo_field == 4'h0)
      else $error("echo not cleared");
   a_data_untouched: assert property (basic_status == 2'h3 && detailed_status == 2'h0 |->
      data_mode == srse_pkg::SRSE_DATA_PASS)
      else $error("sensor data altered");
   a_aux_follows: assert property (1'b1 |=> aux_mode_output_en ==
      !($past(supply_fault) && !$past(supply_fault_mute)))
      else $error("aux enable wrong");
   a_cmd_err_wins: assert property (snap_strobe && $past(spi_cmd_err) |->
      flds == {2'h3, 2'h3, 4'h0, 2'h1})
      else $error("command error not reported");
endmodule : srse_chk
bind srse_top srse_chk i_chk (.clk_sys, .srst, .sel_n, .supply_fault, .supply_fault_mute,
   .spi_cmd_err, .basic_status, .detailed_status, .echo_field, .data_mode,
   .aux_mode_output_en, .snap_strobe);
`default_nettype wire

// *** sim/srse_master.sv ***
// spi master model: drives the select pin around short command frames
// assumes frames are started on a falling edge of the system clock
`timescale 1ns/1ps
`default_nettype none
module srse_master (
   // select pin, active low
   output logic sel_n
);
   logic sclk;
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
   end
   // link clock only toggles inside a frame
   task automatic frame(input int nbits);
      sel_n = 1'b0;
      repeat (nbits) begin
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
      end
      #40 sel_n = 1'b1;
   endtask : frame
endmodule : srse_master
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for srse_top, random and corner snapshots
// assumes srse_master and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_sys, srst, alt_status_sel, supply_fault_mute, init_done, supply_timer_expired;
   logic [7:0] selftest_ctrl;
   logic [0:0] req_channel;
   logic [3:0] cmd_nibble;
   logic [1:0] offset_flag, clip_flag, basic_status, detailed_status;
   logic [10:0] e;
   logic [3:0] echo_field;
   srse_pkg::srse_data_e data_mode;
   wire logic sel_n, aux_mode_output_en, snap_strobe, osc_train_err, temp_err, user_otp_err;
   wire logic user_rw_err, factory_otp_err, test_active, supply_fault, reset_occurred;
   wire logic miso_fault, spi_cmd_err;
   int errors = 0;
   int cmp_count = 0;
   int seed;
   logic [31:0] a, b, c;
   // bit index of e is priority minus one; bit 9 comes from the channel flags
   assign {osc_train_err, temp_err, user_otp_err, user_rw_err, factory_otp_err, test_active,
      supply_fault, reset_occurred, miso_fault, spi_cmd_err} = {e[10], e[8:0]};
   srse_master i_m (.sel_n);
   srse_top #(.NCH(2)) i_dut (.clk_sys, .srst, .sel_n, .alt_status_sel, .supply_fault_mute,
      .init_done, .selftest_ctrl, .req_channel, .cmd_nibble, .osc_train_err, .offset_flag,
      .clip_flag, .temp_err, .user_otp_err, .user_rw_err, .factory_otp_err, .test_active,
      .supply_fault, .supply_timer_expired, .reset_occurred, .miso_fault, .spi_cmd_err,
      .basic_status, .detailed_status, .echo_field, .data_mode, .aux_mode_output_en,
      .snap_strobe);
   ////////////////////////////////////////////////////////////////
   function automatic logic [10:0] expect_f();
      logic [10:0] s;
      logic [3:0] sw;
      logic [1:0] ds, dm;
      int k;
      s = e;
      s[9] = alt_status_sel ? |offset_flag : |(offset_flag | clip_flag);
      sw = {cmd_nibble[0], cmd_nibble[3:1]};
      k = 0;
      while (k < 11 && !s[k]) k++;
      if (k < 11) begin
         ds = k < 3 ? 2'h3 : k < 5 ? 2'h2 : k < 8 ? 2'h1 : 2'h0;
         dm = k > 7 ? 2'h0 : k == 4 ? 2'h2 : k != 3 ? 2'h1 :
            !supply_timer_expired ? 2'h2 : supply_fault_mute ? 2'h0 : 2'h1;
         return {1'b1, 2'h3, ds, k > 7 ? sw : 4'h0, dm};
      end
      if (alt_status_sel ? selftest_ctrl[req_channel*4 +: 4] != 4'h0 : |selftest_ctrl)
         return {1'b1, 2'h2, 2'h0, sw, 2'h0};
      return {1'b1, 1'b0, init_done, 2'h0, sw, 2'h0};
   endfunction : expect_f
   task automatic run_test(input int n);
      logic [10:0] exp, got;
      int w;
      exp = expect_f();
      i_m.frame(4);
      w = 0;
      do begin
         @(posedge clk_sys);
         #1;
         w++;
      end while (snap_strobe !== 1'b1 && w < 20);
      got = {snap_strobe, basic_status, detailed_status, echo_field, data_mode};
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
      cmp_count++;
      if (aux_mode_output_en !== !(e[3] && !supply_fault_mute)) begin
         errors++;
         $display("[FAIL] t=%0t aux got=%h exp=%h", $time, aux_mode_output_en,
            !(e[3] && !supply_fault_mute));
      end
      $display("test %0d done", n);
   endtask : run_test
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      #100000;
      errors++;
      give_verdict();
   end
   initial begin
      seed = 32'hb78e;
      {srst, alt_status_sel, supply_fault_mute, init_done, supply_timer_expired} = 5'h11;
      {selftest_ctrl, req_channel, cmd_nibble, offset_flag, clip_flag, e} = 28'h0;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      srst = 1'b0;
      init_done = 1'b1;
      cmd_nibble = 4'h9;
      // each source alone, the four supply cases, then every source at once
      for (int k = 0; k < 16; k++) begin
         @(negedge clk_sys);
         e = k > 10 ? (k == 15 ? 11'h7ff : 11'h008) : 11'h001 << k;
         offset_flag = {1'b0, k == 9 || k == 15};
         supply_fault_mute = k[0] && k > 10;
         supply_timer_expired = k[1] && k > 10;
         run_test(k);
      end
      // alt corners: clip ignored, self-test only on the requested channel, init, std clip
      for (int k = 16; k < 20; k++) begin
         @(negedge clk_sys);
         e = 11'h000;
         offset_flag = 2'h0;
         clip_flag = 2'h3;
         alt_status_sel = k != 19;
         selftest_ctrl = k == 16 ? 8'h00 : 8'h50;
         req_channel = k == 18;
         init_done = k != 16;
         run_test(k);
      end
      for (int k = 20; k < 60; k++) begin
         @(negedge clk_sys);
         a = $random(seed);
         b = $random(seed);
         c = $random(seed);
         e = a[10:0] & b[10:0] & c[10:0];
         {alt_status_sel, supply_fault_mute, init_done, supply_timer_expired, req_channel,
            cmd_nibble} = a[24:16];
         offset_flag = b[13:12] & c[13:12];
         clip_flag = b[15:14] & c[15:14];
         selftest_ctrl = b[23:16] & c[23:16] & {8{a[25]}};
         run_test(k);
      end
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
